// file: verilog/tfh_pkg.sv
// Overview of operation
// [R1] Host never writes receive buffer headers.
// [R2] Transmit headers writable in configuration or disabled.
// [R3] Dynamic locked buffers: all but identifier writable.
// [R4] Null, sync, startup, cycle generated internally.
// [R5] Static buffer length must equal configured length.
// [R6] Static length mismatch sets static error flag.
// [R7] Static frame always sends configured length.
// [R8] Dynamic length must not exceed configured maximum.
// [R9] Dynamic length excess sets dynamic error flag.
// [R10] Dynamic frame sends programmed buffer length.
// [R11] Receive buffers store received reserved bit.
// [R12] Transmit reserved bit sent unchanged.
// [R13] Host should program transmit reserved bit zero.
// [R14] Transmit preamble bit copied into header.
// [R15] Receive preamble bit of first valid frame.
// [R16] Preamble marks management vector or message identifier.
// [R17] Identifier mismatch flags error, sends configured identifier.
// [R18] Cycle number replaced by current cycle count.
// [R19] Header fields read and checked at handover.
package tfh_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Field widths
	localparam int FID_W = 11;
	localparam int LEN_W = 7;
	localparam int CRC_W = 11;
	localparam int CYC_W = 6;
	localparam int FLAG_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_ERROR = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_STATIC_LEN = 8'h08;
	localparam logic [7:0] OFS_DYN_LEN = 8'h0C;
	localparam logic [7:0] OFS_RX_STATUS = 8'h10;

	////////////////////////////////////////////////////////////////////////////
	// Bit positions in the error, mask and rx status registers
	localparam int BIT_STATIC_LEN = 0;
	localparam int BIT_DYN_LEN = 1;
	localparam int BIT_FID = 2;
	localparam int BIT_WRITE_VIOL = 3;
	localparam int BIT_RX_RESERVED = 0;
	localparam int BIT_RX_PREAMBLE = 1;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [FLAG_W-1:0] RST_ERROR = 4'h0;
	localparam logic [FLAG_W-1:0] RST_MASK = 4'h0;
	localparam logic [LEN_W-1:0] RST_STATIC_LEN = 7'h00;
	localparam logic [LEN_W-1:0] RST_DYN_LEN = 7'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Frame header as kept in controller memory and as sent
	typedef struct packed {
		logic reserved_bit;
		logic payload_preamble_bit;
		logic null_frame_indicator;
		logic sync_frame_indicator;
		logic startup_frame_indicator;
		logic [FID_W-1:0] frame_identifier;
		logic [LEN_W-1:0] payload_word_count;
		logic [CRC_W-1:0] header_checksum;
		logic [CYC_W-1:0] cycle_number;
	} tfh_header_type;

	// Transmit handover from the protocol engine
	typedef struct packed {
		logic start;
		logic dynamic_segment;
		logic [FID_W-1:0] buffer_identifier_register;
		logic null_frame;
		logic sync_frame;
		logic startup_frame;
		logic [CYC_W-1:0] current_cycle;
	} tfh_tx_ctrl_type;

	// Host header write attempt seen by the memory arbiter
	typedef struct packed {
		logic valid;
		logic receive_buffer;
		logic identifier_entry;
		logic dynamic_segment;
		logic buffer_disabled;
		logic buffer_locked;
	} tfh_hdr_write_type;

	// Received frame header for a receive or queue buffer
	typedef struct packed {
		logic valid;
		logic first_valid;
		tfh_header_type header;
	} tfh_rx_frame_type;

	// Bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} tfh_bus_state_type;

endpackage

// file: verilog/tfh_sticky_flags.sv
`timescale 1ns/1ns
// Sticky event flags, cleared by writing one; a set wins over a clear
module tfh_sticky_flags #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clear,
	output logic [W-1:0] flags
);

	////////////////////////////////////////////////////////////////////////////
	// Flag storage
	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	// Set has priority over write-one-to-clear in the same cycle
	always_comb begin
		flags_next = (flags_reg & ~clear) | set;
	end

	// Hold while the clock enable is low
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_reg <= '0;
		end else if (ce) begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;

endmodule

// file: verilog/tfh_frame_header.sv
`timescale 1ns/1ns
// Transmit frame header handler with Avalon-MM register slave
module tfh_frame_header (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Protocol state
	input wire logic protocol_configuration_state,
	// Host header write attempts
	input wire tfh_pkg::tfh_hdr_write_type hdr_write,
	output logic hdr_write_allow,
	// Transmit handover
	input wire tfh_pkg::tfh_tx_ctrl_type tx_ctrl,
	input wire tfh_pkg::tfh_header_type tx_stored,
	output tfh_pkg::tfh_header_type tx_header,
	output logic [tfh_pkg::LEN_W-1:0] tx_payload_words,
	output logic tx_nm_vector,
	output logic tx_message_id,
	output logic tx_valid,
	// Received frames
	input wire tfh_pkg::tfh_rx_frame_type rx_frame,
	output logic rx_reserved_status,
	output logic rx_preamble_status,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [tfh_pkg::FLAG_W-1:0] mask_reg; // Interrupt mask
	logic [tfh_pkg::LEN_W-1:0] static_len_reg; // Configured static length
	logic [tfh_pkg::LEN_W-1:0] dyn_len_reg; // Configured maximum dynamic length
	logic [tfh_pkg::FLAG_W-1:0] err_flags; // Interface error register
	logic [tfh_pkg::FLAG_W-1:0] err_set; // Events this cycle
	logic [tfh_pkg::FLAG_W-1:0] err_clear; // Write-one-to-clear mask
	logic [31:0] readdata_reg; // Read data
	logic [31:0] readdata_next; // Read mux
	logic waitrequest_reg; // Handshake output
	logic irq_reg; // Interrupt output
	tfh_pkg::tfh_bus_state_type bus_state_reg; // Handshake state
	tfh_pkg::tfh_bus_state_type bus_state_next; // Next handshake state

	////////////////////////////////////////////////////////////////////////////
	// Output state
	tfh_pkg::tfh_header_type tx_header_reg; // Outgoing header
	logic [tfh_pkg::LEN_W-1:0] tx_words_reg; // Payload words to send
	logic tx_nm_reg; // Payload opens with management vector
	logic tx_msgid_reg; // Payload opens with message identifier
	logic tx_valid_reg; // Header valid pulse
	logic rx_reserved_reg; // Received reserved bit
	logic rx_preamble_reg; // Received preamble bit
	logic allow_reg; // Write permission

	////////////////////////////////////////////////////////////////////////////
	// Transmit checks, combinational
	logic static_mismatch; // Static length differs
	logic dyn_excess; // Dynamic length too large
	logic fid_mismatch; // Identifier differs from configuration
	logic write_ok; // Header write permitted
	logic write_viol; // Header write refused

	// Bus access decode
	logic bus_req; // Read or write pending
	logic bus_take; // Cycle in which the access completes
	logic wr_take; // Write completes this cycle
	logic lane0; // Low byte lane enabled

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake state machine
	assign bus_req = avs_read | avs_write;
	assign bus_take = bus_req & (bus_state_reg == tfh_pkg::BUS_ACK);
	assign wr_take = avs_write & bus_take;
	assign lane0 = avs_byteenable[0];

	// One wait cycle, then acknowledge, then back to idle
	always_comb begin
		case (bus_state_reg)
			tfh_pkg::BUS_IDLE: begin
				// Request seen, answer next edge
				bus_state_next = bus_req ? tfh_pkg::BUS_ACK : tfh_pkg::BUS_IDLE;
			end
			tfh_pkg::BUS_ACK: begin
				// Access completes here
				bus_state_next = tfh_pkg::BUS_IDLE;
			end
			default: begin
				// Recover from an illegal code
				bus_state_next = tfh_pkg::BUS_IDLE;
			end
		endcase
	end

	// Handshake state register
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_state_reg <= tfh_pkg::BUS_IDLE;
		end else if (ce) begin
			bus_state_reg <= bus_state_next;
		end
	end

	// Waitrequest low only in the acknowledge cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			waitrequest_reg <= 1'b1;
		end else if (ce) begin
			waitrequest_reg <= ~(bus_req & (bus_state_next == tfh_pkg::BUS_ACK));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux, unmapped offsets read zero
	always_comb begin
		readdata_next = tfh_pkg::RST_RDATA;
		case (avs_address)
			tfh_pkg::OFS_ERROR: begin
				readdata_next[tfh_pkg::FLAG_W-1:0] = err_flags;
			end
			tfh_pkg::OFS_MASK: begin
				readdata_next[tfh_pkg::FLAG_W-1:0] = mask_reg;
			end
			tfh_pkg::OFS_STATIC_LEN: begin
				readdata_next[tfh_pkg::LEN_W-1:0] = static_len_reg;
			end
			tfh_pkg::OFS_DYN_LEN: begin
				readdata_next[tfh_pkg::LEN_W-1:0] = dyn_len_reg;
			end
			tfh_pkg::OFS_RX_STATUS: begin
				readdata_next[tfh_pkg::BIT_RX_RESERVED] = rx_reserved_reg;
				readdata_next[tfh_pkg::BIT_RX_PREAMBLE] = rx_preamble_reg;
			end
			default: begin
				// Unmapped: zero
				readdata_next = tfh_pkg::RST_RDATA;
			end
		endcase
	end

	// Read data captured as waitrequest falls
	always_ff @(posedge clk) begin
		if (srst) begin
			readdata_reg <= tfh_pkg::RST_RDATA;
		end else if (ce) begin
			if (avs_read && bus_state_next == tfh_pkg::BUS_ACK) begin
				readdata_reg <= readdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers, low byte lane only
	always_ff @(posedge clk) begin
		if (srst) begin
			mask_reg <= tfh_pkg::RST_MASK;
			static_len_reg <= tfh_pkg::RST_STATIC_LEN;
			dyn_len_reg <= tfh_pkg::RST_DYN_LEN;
		end else if (ce && wr_take && lane0) begin
			case (avs_address)
				tfh_pkg::OFS_MASK: begin
					mask_reg <= avs_writedata[tfh_pkg::FLAG_W-1:0];
				end
				tfh_pkg::OFS_STATIC_LEN: begin
					static_len_reg <= avs_writedata[tfh_pkg::LEN_W-1:0];
				end
				tfh_pkg::OFS_DYN_LEN: begin
					dyn_len_reg <= avs_writedata[tfh_pkg::LEN_W-1:0];
				end
				default: begin
					// Other offsets hold nothing writable here
				end
			endcase
		end
	end

	// Write-one-to-clear of the error flags
	always_comb begin
		err_clear = '0;
		if (wr_take && lane0 && avs_address == tfh_pkg::OFS_ERROR) begin
			err_clear = avs_writedata[tfh_pkg::FLAG_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Header write guard for the shared memory arbiter
	always_comb begin
		if (hdr_write.receive_buffer) begin
			// Receive headers are never host-writable
			write_ok = 1'b0; // [R1]
		end else if (protocol_configuration_state || hdr_write.buffer_disabled) begin
			// Any entry may change
			write_ok = 1'b1; // [R2]
		end else if (hdr_write.dynamic_segment && hdr_write.buffer_locked) begin
			// All but the identifier may change
			write_ok = ~hdr_write.identifier_entry; // [R3]
		end else begin
			// Buffer live: keep consistent
			write_ok = 1'b0;
		end
	end

	assign write_viol = hdr_write.valid & ~write_ok;

	// Registered permission toward the arbiter
	always_ff @(posedge clk) begin
		if (srst) begin
			allow_reg <= 1'b0;
		end else if (ce) begin
			allow_reg <= hdr_write.valid & write_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit checks at handover time
	assign static_mismatch = ~tx_ctrl.dynamic_segment & (tx_stored.payload_word_count != static_len_reg); // [R5]
	assign dyn_excess = tx_ctrl.dynamic_segment & (tx_stored.payload_word_count > dyn_len_reg); // [R8]
	assign fid_mismatch = tx_stored.frame_identifier != tx_ctrl.buffer_identifier_register;

	// Length and identifier error events raised only for a buffer under transmission
	always_comb begin
		err_set = '0;
		err_set[tfh_pkg::BIT_STATIC_LEN] = tx_ctrl.start & static_mismatch; // [R6] [R19]
		err_set[tfh_pkg::BIT_DYN_LEN] = tx_ctrl.start & dyn_excess; // [R9] [R19]
		err_set[tfh_pkg::BIT_FID] = tx_ctrl.start & fid_mismatch; // [R17]
		err_set[tfh_pkg::BIT_WRITE_VIOL] = write_viol;
	end

	// Sticky error flags with set priority
	tfh_sticky_flags #(
		.W(tfh_pkg::FLAG_W)
	) u_err_flags (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.set(err_set),
		.clear(err_clear),
		.flags(err_flags)
	);

	// Level interrupt from unmasked flags
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_reg <= 1'b0;
		end else if (ce) begin
			irq_reg <= |(((err_flags & ~err_clear) | err_set) & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outgoing header assembly, sampled at handover
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_header_reg <= '0;
			tx_words_reg <= '0;
			tx_nm_reg <= 1'b0;
			tx_msgid_reg <= 1'b0;
		end else if (ce && tx_ctrl.start) begin
			// Stored reserved and preamble bits pass through
			tx_header_reg.reserved_bit <= tx_stored.reserved_bit; // [R12] [R13]
			tx_header_reg.payload_preamble_bit <= tx_stored.payload_preamble_bit; // [R14]
			// Indicators come from the engine, not memory
			tx_header_reg.null_frame_indicator <= tx_ctrl.null_frame; // [R4]
			tx_header_reg.sync_frame_indicator <= tx_ctrl.sync_frame; // [R4]
			tx_header_reg.startup_frame_indicator <= tx_ctrl.startup_frame; // [R4]
			// Configured identifier always sent
			tx_header_reg.frame_identifier <= tx_ctrl.buffer_identifier_register; // [R17]
			tx_header_reg.header_checksum <= tx_stored.header_checksum;
			// Current cycle replaces the stored count
			tx_header_reg.cycle_number <= tx_ctrl.current_cycle; // [R4] [R18]
			if (tx_ctrl.dynamic_segment) begin
				// Programmed length, even if over the maximum
				tx_header_reg.payload_word_count <= tx_stored.payload_word_count; // [R10]
				tx_words_reg <= tx_stored.payload_word_count; // [R10]
			end else begin
				// Configured static length regardless of memory
				tx_header_reg.payload_word_count <= static_len_reg; // [R7]
				tx_words_reg <= static_len_reg; // [R7]
			end
			// Preamble meaning depends on segment
			tx_nm_reg <= tx_stored.payload_preamble_bit & ~tx_ctrl.dynamic_segment; // [R16]
			tx_msgid_reg <= tx_stored.payload_preamble_bit & tx_ctrl.dynamic_segment; // [R16]
		end
	end

	// One-cycle valid after handover
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_valid_reg <= 1'b0;
		end else if (ce) begin
			tx_valid_reg <= tx_ctrl.start;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive status bits
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_reserved_reg <= 1'b0;
			rx_preamble_reg <= 1'b0;
		end else if (ce && rx_frame.valid) begin
			// Reserved bit of any frame in the slot
			rx_reserved_reg <= rx_frame.header.reserved_bit; // [R11]
			if (rx_frame.first_valid) begin
				// Preamble of the first valid frame only
				rx_preamble_reg <= rx_frame.header.payload_preamble_bit; // [R15]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign avs_readdata = readdata_reg;
	assign avs_waitrequest = waitrequest_reg;
	assign hdr_write_allow = allow_reg;
	assign tx_header = tx_header_reg;
	assign tx_payload_words = tx_words_reg;
	assign tx_nm_vector = tx_nm_reg;
	assign tx_message_id = tx_msgid_reg;
	assign tx_valid = tx_valid_reg;
	assign rx_reserved_status = rx_reserved_reg;
	assign rx_preamble_status = rx_preamble_reg;
	assign irq = irq_reg;

endmodule

// file: tb/tfh_frame_header_chk.sv
`timescale 1ns/1ns
// Port-level checks of the frame header handler
module tfh_frame_header_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic protocol_configuration_state,
	input wire tfh_pkg::tfh_hdr_write_type hdr_write,
	input wire logic hdr_write_allow,
	input wire tfh_pkg::tfh_tx_ctrl_type tx_ctrl,
	input wire tfh_pkg::tfh_header_type tx_stored,
	input wire tfh_pkg::tfh_header_type tx_header,
	input wire logic [tfh_pkg::LEN_W-1:0] tx_payload_words,
	input wire logic tx_nm_vector,
	input wire logic tx_message_id,
	input wire logic tx_valid,
	input wire tfh_pkg::tfh_rx_frame_type rx_frame,
	input wire logic rx_reserved_status,
	input wire logic rx_preamble_status
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	tfh_pkg::tfh_tx_ctrl_type ctl_q; // Handover control of the last edge
	tfh_pkg::tfh_header_type sto_q; // Stored header of the last edge
	tfh_pkg::tfh_rx_frame_type rx_q; // Received frame of the last edge

	////////////////////////////////////////////////////////////////////////////
	// Capture inputs one edge back
	always_ff @(posedge clk) begin
		ctl_q <= tx_ctrl;
		sto_q <= tx_stored;
		rx_q <= rx_frame;
	end

	////////////////////////////////////////////////////////////////////////////
	// Steps of the bus answer and of a handover
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest && ce;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence s_start;
		tx_ctrl.start && ce;
	endsequence
	property p_bus_ack;
		s_req |=> s_ack;
	endproperty
	property p_tx_valid;
		s_start ##1 !tx_ctrl.start |-> tx_valid ##1 !tx_valid;
	endproperty
	property p_tx_gen;
		s_start |=> {tx_header.null_frame_indicator, tx_header.sync_frame_indicator,
			tx_header.startup_frame_indicator} == {ctl_q.null_frame, ctl_q.sync_frame, ctl_q.startup_frame};
	endproperty
	property p_tx_cycle;
		s_start |=> tx_header.cycle_number == ctl_q.current_cycle;
	endproperty
	property p_tx_fid;
		s_start |=> tx_header.frame_identifier == ctl_q.buffer_identifier_register;
	endproperty
	property p_tx_bits;
		s_start |=> tx_header.reserved_bit == sto_q.reserved_bit
			&& tx_header.payload_preamble_bit == sto_q.payload_preamble_bit;
	endproperty
	property p_dyn_len;
		tx_ctrl.start && ce && tx_ctrl.dynamic_segment |=> tx_payload_words == sto_q.payload_word_count
			&& tx_header.payload_word_count == sto_q.payload_word_count;
	endproperty
	property p_ppi;
		s_start |=> tx_nm_vector == (sto_q.payload_preamble_bit && !ctl_q.dynamic_segment)
			&& tx_message_id == (sto_q.payload_preamble_bit && ctl_q.dynamic_segment);
	endproperty
	property p_rx_res;
		rx_frame.valid && ce |=> rx_reserved_status == rx_q.header.reserved_bit;
	endproperty
	property p_rx_pre;
		rx_frame.valid && rx_frame.first_valid && ce |=> rx_preamble_status == rx_q.header.payload_preamble_bit;
	endproperty
	property p_rx_keep;
		rx_frame.valid && !rx_frame.first_valid && ce |=> $stable(rx_preamble_status);
	endproperty
	property p_guard_rx;
		hdr_write.valid && hdr_write.receive_buffer && ce |=> !hdr_write_allow;
	endproperty
	property p_guard_ok;
		hdr_write.valid && !hdr_write.receive_buffer && ce
			&& (protocol_configuration_state || hdr_write.buffer_disabled) |=> hdr_write_allow;
	endproperty

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_bus_ack: assert property (p_bus_ack) else $error("bus answer not in one wait cycle");
	a_tx_valid: assert property (p_tx_valid) else $error("tx_valid not a one cycle pulse");
	a_tx_gen: assert property (p_tx_gen) else $error("frame kind bits not generated");
	a_tx_cycle: assert property (p_tx_cycle) else $error("cycle number not current");
	a_tx_fid: assert property (p_tx_fid) else $error("identifier not the configured one");
	a_tx_bits: assert property (p_tx_bits) else $error("control bits not copied");
	a_dyn_len: assert property (p_dyn_len) else $error("dynamic length not programmed one");
	a_ppi: assert property (p_ppi) else $error("preamble meaning wrong");
	a_rx_res: assert property (p_rx_res) else $error("reserved status not stored");
	a_rx_pre: assert property (p_rx_pre) else $error("preamble status not stored");
	a_rx_keep: assert property (p_rx_keep) else $error("preamble status changed late");
	a_guard_rx: assert property (p_guard_rx) else $error("receive header write allowed");
	a_guard_ok: assert property (p_guard_ok) else $error("legal header write refused");
endmodule

bind tfh_frame_header tfh_frame_header_chk i_chk (.clk(clk), .srst(srst), .ce(ce), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.protocol_configuration_state(protocol_configuration_state), .hdr_write(hdr_write),
	.hdr_write_allow(hdr_write_allow), .tx_ctrl(tx_ctrl), .tx_stored(tx_stored), .tx_header(tx_header),
	.tx_payload_words(tx_payload_words), .tx_nm_vector(tx_nm_vector), .tx_message_id(tx_message_id),
	.tx_valid(tx_valid), .rx_frame(rx_frame), .rx_reserved_status(rx_reserved_status),
	.rx_preamble_status(rx_preamble_status));

// file: tb/tfh_host_mem.sv
`timescale 1ns/1ns
// Host side of controller memory: one transmit header
module tfh_host_mem (
	input wire logic clk,
	input wire logic wr,
	input wire logic cfg,
	input wire logic rsv_ok,
	input wire tfh_pkg::tfh_header_type hdr,
	output tfh_pkg::tfh_header_type stored
);
	tfh_pkg::tfh_header_type mem_reg = '0; // Stored transmit header

	assign stored = mem_reg;

	// Host writes a transmit header only in configuration state
	always_ff @(posedge clk) begin
		if (wr && cfg) begin
			mem_reg <= hdr;
			if (!rsv_ok) begin
				mem_reg.reserved_bit <= 1'h0;
			end
		end
	end
endmodule

// file: tb/test_tfh_frame_header.sv
`timescale 1ns/1ns
// Self-checking bench of the frame header handler
module test_tfh_frame_header;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic ce = 1'h1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic protocol_configuration_state = 1'h0;
	tfh_pkg::tfh_hdr_write_type hdr_write = '0;
	logic hdr_write_allow;
	tfh_pkg::tfh_tx_ctrl_type tx_ctrl = '0;
	tfh_pkg::tfh_header_type tx_stored;
	tfh_pkg::tfh_header_type tx_header;
	logic [tfh_pkg::LEN_W-1:0] tx_payload_words;
	logic tx_nm_vector;
	logic tx_message_id;
	logic tx_valid;
	tfh_pkg::tfh_rx_frame_type rx_frame = '0;
	logic rx_reserved_status;
	logic rx_preamble_status;
	logic irq;
	logic hm_wr = 1'h0; // Host memory write
	logic hm_rsv_ok = 1'h0; // Host keeps a set reserved bit
	tfh_pkg::tfh_header_type hm_hdr = '0; // Header the host writes
	int n_errors = 0;
	int comparisons = 0;
	int m_err = 0; // Model of the error flags
	int m_mask = 0;
	int m_slen = 0;
	int m_dlen = 0;
	int m_rx = 0; // Model of the rx status bits
	int m_q[$]; // Queue of expected register images

	always #20 clk = ~clk;

	tfh_frame_header i_dut (.clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.protocol_configuration_state(protocol_configuration_state), .hdr_write(hdr_write),
		.hdr_write_allow(hdr_write_allow), .tx_ctrl(tx_ctrl), .tx_stored(tx_stored), .tx_header(tx_header),
		.tx_payload_words(tx_payload_words), .tx_nm_vector(tx_nm_vector), .tx_message_id(tx_message_id),
		.tx_valid(tx_valid), .rx_frame(rx_frame), .rx_reserved_status(rx_reserved_status),
		.rx_preamble_status(rx_preamble_status), .irq(irq));

	tfh_host_mem i_host (.clk(clk), .wr(hm_wr), .cfg(protocol_configuration_state), .rsv_ok(hm_rsv_ok),
		.hdr(hm_hdr), .stored(tx_stored));

	////////////////////////////////////////////////////////////////////////////
	// Compare, bus cycles and register model
	task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input int d);
		logic [31:0] q;
		bus(1'h0, a, 32'(d), q);
		case (a)
			tfh_pkg::OFS_ERROR: m_err = m_err & ~d;
			tfh_pkg::OFS_MASK: m_mask = d & 15;
			tfh_pkg::OFS_STATIC_LEN: m_slen = d & 127;
			tfh_pkg::OFS_DYN_LEN: m_dlen = d & 127;
			default: ;
		endcase
	endtask

	task automatic rdc(input logic [7:0] a);
		logic [31:0] q;
		m_q = '{m_err, m_mask, m_slen, m_dlen, m_rx, 0};
		bus(1'h1, a, 32'h0000_0000, q);
		chk("readdata", 40'(q), 40'(m_q[a[4:2]]));
		chk("irq", 40'(irq), 40'((m_err & m_mask) != 0));
	endtask

	task automatic finish_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#(40 * 30000);
		n_errors++;
		finish_test;
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int r;
		int k;
		int len;
		logic [63:0] w;
		tfh_pkg::tfh_header_type h;
		tfh_pkg::tfh_header_type e;
		tfh_pkg::tfh_tx_ctrl_type c;
		r = $urandom(53);
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		for (k = 0; k <= 20; k += 4) rdc(8'(k));
		wr(tfh_pkg::OFS_STATIC_LEN, $urandom_range(1, 100));
		wr(tfh_pkg::OFS_DYN_LEN, $urandom_range(1, 100));
		wr(tfh_pkg::OFS_MASK, 15);
		wr(8'h14, 255);
		wr(tfh_pkg::OFS_RX_STATUS, 3);
		for (k = 0; k <= 20; k += 4) rdc(8'(k));
		// Header write attempts in 40 random combinations of state
		repeat (40) begin
			r = $urandom;
			protocol_configuration_state <= r[0];
			ce <= r[6];
			hdr_write <= {1'h1, r[5:1]};
			@(posedge clk);
			hdr_write <= '0;
			@(posedge clk);
			k = r[6] && !r[5] && (r[0] || r[2] || (r[3] && r[1] && !r[4]));
			chk("hdr_write_allow", 40'(hdr_write_allow), 40'(k));
			if (r[6] && k == 0) m_err = m_err | 8;
		end
		ce <= 1'h1;
		rdc(tfh_pkg::OFS_ERROR);
		wr(tfh_pkg::OFS_ERROR, 8);
		rdc(tfh_pkg::OFS_ERROR);
		// Handovers with lengths at the limits and identifier mismatches
		repeat (60) begin
			r = $urandom;
			w = {$urandom, $urandom};
			h = w[39:0];
			case (r[3:2])
				0: len = m_slen;
				1: len = m_dlen;
				2: len = m_dlen + 1;
				default: len = h.payload_word_count;
			endcase
			h.payload_word_count = 7'(len);
			c = {1'h1, r[4], r[0] ? h.frame_identifier : w[50:40], w[63:55]};
			hm_hdr <= h;
			hm_rsv_ok <= r[5];
			hm_wr <= 1'h1;
			protocol_configuration_state <= 1'h1;
			@(posedge clk);
			hm_wr <= 1'h0;
			tx_ctrl <= c;
			@(posedge clk);
			tx_ctrl <= '0;
			@(posedge clk);
			e = h;
			e.reserved_bit = h.reserved_bit & r[5];
			{e.null_frame_indicator, e.sync_frame_indicator, e.startup_frame_indicator} = w[63:61];
			e.cycle_number = c.current_cycle;
			e.frame_identifier = c.buffer_identifier_register;
			if (!c.dynamic_segment) e.payload_word_count = 7'(m_slen);
			chk("tx_valid", 40'(tx_valid), 40'(1));
			chk("tx_header", tx_header, e);
			chk("tx_payload_words", 40'(tx_payload_words), 40'(e.payload_word_count));
			chk("tx_nm_vector", 40'(tx_nm_vector), 40'(h.payload_preamble_bit & !r[4]));
			chk("tx_message_id", 40'(tx_message_id), 40'(h.payload_preamble_bit & r[4]));
			if (!r[4] && len != m_slen) m_err = m_err | 1;
			if (r[4] && len > m_dlen) m_err = m_err | 2;
			if (!r[0] && h.frame_identifier != c.buffer_identifier_register) m_err = m_err | 4;
			rdc(tfh_pkg::OFS_ERROR);
			wr(tfh_pkg::OFS_MASK, $urandom_range(0, 15));
			wr(tfh_pkg::OFS_ERROR, $urandom_range(0, 15));
		end
		// Received frames, first valid or not
		repeat (20) begin
			r = $urandom;
			w = {$urandom, $urandom};
			rx_frame <= {1'h1, r[0], w[39:0]};
			@(posedge clk);
			rx_frame <= '0;
			@(posedge clk);
			m_rx = r[0] ? 32'({w[38], w[39]}) : ((m_rx & 2) | 32'(w[39]));
			chk("rx_reserved_status", 40'(rx_reserved_status), 40'(m_rx & 1));
			chk("rx_preamble_status", 40'(rx_preamble_status), 40'(m_rx >> 1));
			rdc(tfh_pkg::OFS_RX_STATUS);
		end
		finish_test;
	end
endmodule
